// [rtl/ddps_regs.sv]
// pointer/stack/port0 register bank with port0 pin and bus muxing
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - stack pointer pre-increments on push, pre-decrements on pop
// - stack pointer resets to 07h
// - select bit picks pointer A or B
// - each pointer is high:low 16-bit address
// - selected pointer, output as active_data_pointer, addresses external data memory
// - port0 carries address under ALE, else data, while a bus cycle is active in bus mode
// - direction registers set port0 GPIO drive
// - config bit selects port0 GPIO or bus
module ddps_regs (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic [7:0]                reg_addr,
    input  wire logic [7:0]                reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic      [7:0]                reg_rdata,
    input  wire ddps_pkg::ddps_core_op_t   core_op,
    input  wire ddps_pkg::ddps_ext_cycle_t ext_cycle,
    output logic      [7:0]                stack_addr,
    output logic      [15:0]               active_data_pointer,
    output logic      [15:0]               pointer_a,
    input  wire logic [7:0]                port0_in,
    output logic      [7:0]                port0_out,
    output logic      [7:0]                port0_oe,
    output logic      [7:0]                ext_rdata
);

    logic [7:0]  port0_latch;
    logic [7:0]  stack_top_pointer;
    logic [7:0]  pointer_a_low;
    logic [7:0]  pointer_a_high;
    logic [7:0]  pointer_b_low;
    logic [7:0]  pointer_b_high;
    logic        pointer_select;
    logic [7:0]  port0_direction_low;
    logic [7:0]  port0_direction_high;
    logic [7:0]  hardware_config_one;
    logic        ext_bus_mode;
    logic [15:0] next_active_data_pointer;
    logic [7:0]  next_rdata;
    logic [7:0]  next_p0_out;
    logic [7:0]  next_p0_oe;

    function automatic logic wr_hit(input logic [7:0] a);
        return reg_wr && (reg_addr == a);
    endfunction

    assign ext_bus_mode = hardware_config_one[ddps_pkg::EXT_BUS_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // stack pointer
    always_ff @(posedge clk) begin
        if (rst) begin
            stack_top_pointer <= ddps_pkg::RST_STACK_TOP;
        end else if (wr_hit(ddps_pkg::ADDR_STACK_TOP)) begin
            stack_top_pointer <= reg_wdata;
        end else if (core_op.push) begin
            stack_top_pointer <= stack_top_pointer + 8'h01;
        end else if (core_op.pop) begin
            stack_top_pointer <= stack_top_pointer - 8'h01;
        end
    end

    // push writes at the incremented slot; pop moves stack_addr to the decremented slot
    always_ff @(posedge clk) begin
        if (rst) begin
            stack_addr <= ddps_pkg::RST_STACK_TOP;
        end else if (wr_hit(ddps_pkg::ADDR_STACK_TOP)) begin
            stack_addr <= reg_wdata;
        end else if (core_op.push) begin
            stack_addr <= stack_top_pointer + 8'h01;
        end else if (core_op.pop) begin
            stack_addr <= stack_top_pointer - 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // data pointers
    always_comb begin
        next_active_data_pointer = pointer_select ? {pointer_b_high, pointer_b_low}
                                   : {pointer_a_high, pointer_a_low};
        if (core_op.active_data_pointer_load) begin
            next_active_data_pointer = core_op.active_data_pointer_value;
        end else if (core_op.active_data_pointer_inc) begin
            next_active_data_pointer = next_active_data_pointer + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pointer_a_low  <= ddps_pkg::RST_PTR_BYTE;
            pointer_a_high <= ddps_pkg::RST_PTR_BYTE;
        end else if ((core_op.active_data_pointer_load || core_op.active_data_pointer_inc) && !pointer_select) begin
            {pointer_a_high, pointer_a_low} <= next_active_data_pointer;
        end else begin
            if (wr_hit(ddps_pkg::ADDR_PTR_A_LOW)) begin
                pointer_a_low <= reg_wdata;
            end
            if (wr_hit(ddps_pkg::ADDR_PTR_A_HIGH)) begin
                pointer_a_high <= reg_wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pointer_b_low  <= ddps_pkg::RST_PTR_BYTE;
            pointer_b_high <= ddps_pkg::RST_PTR_BYTE;
        end else if ((core_op.active_data_pointer_load || core_op.active_data_pointer_inc) && pointer_select) begin
            {pointer_b_high, pointer_b_low} <= next_active_data_pointer;
        end else begin
            if (wr_hit(ddps_pkg::ADDR_PTR_B_LOW)) begin
                pointer_b_low <= reg_wdata;
            end
            if (wr_hit(ddps_pkg::ADDR_PTR_B_HIGH)) begin
                pointer_b_high <= reg_wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pointer_select <= ddps_pkg::RST_PTR_SELECT[ddps_pkg::SEL_BIT];
        end else if (wr_hit(ddps_pkg::ADDR_PTR_SELECT)) begin
            pointer_select <= reg_wdata[ddps_pkg::SEL_BIT];
        end
    end

    // outputs follow the registers one cycle later, from flops
    always_ff @(posedge clk) begin
        if (rst) begin
            active_data_pointer <= {ddps_pkg::RST_PTR_BYTE, ddps_pkg::RST_PTR_BYTE};
            pointer_a           <= {ddps_pkg::RST_PTR_BYTE, ddps_pkg::RST_PTR_BYTE};
        end else begin
            active_data_pointer <= pointer_select ? {pointer_b_high, pointer_b_low}
                                                  : {pointer_a_high, pointer_a_low};
            pointer_a           <= {pointer_a_high, pointer_a_low};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // port0 latch, direction and configuration
    always_ff @(posedge clk) begin
        if (rst) begin
            port0_latch          <= ddps_pkg::RST_PORT0_LATCH;
            port0_direction_low  <= ddps_pkg::RST_P0_DIR;
            port0_direction_high <= ddps_pkg::RST_P0_DIR;
            hardware_config_one  <= ddps_pkg::RST_HW_CONFIG1;
        end else begin
            if (wr_hit(ddps_pkg::ADDR_PORT0_LATCH)) begin
                port0_latch <= reg_wdata;
            end
            if (wr_hit(ddps_pkg::ADDR_P0_DIR_LOW)) begin
                port0_direction_low <= reg_wdata;
            end
            if (wr_hit(ddps_pkg::ADDR_P0_DIR_HIGH)) begin
                port0_direction_high <= reg_wdata;
            end
            if (wr_hit(ddps_pkg::ADDR_HW_CONFIG1)) begin
                hardware_config_one <= reg_wdata;
            end
        end
    end

    // pin drive: bus cycle overrides GPIO when configured
    always_comb begin
        next_p0_out = port0_latch;
        next_p0_oe  = port0_direction_low | port0_direction_high;
        if (ext_bus_mode && ext_cycle.active) begin
            if (ext_cycle.ale) begin
                next_p0_out = ext_cycle.addr_low;
                next_p0_oe  = 8'hFF;
            end else begin
                next_p0_out = ext_cycle.wdata;
                next_p0_oe  = ext_cycle.write ? 8'hFF : 8'h00;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            port0_out <= ddps_pkg::RST_PORT0_LATCH;
            port0_oe  <= ddps_pkg::RST_P0_DIR;
            ext_rdata <= 8'h00;
        end else begin
            port0_out <= next_p0_out;
            port0_oe  <= next_p0_oe;
            if (ext_bus_mode && ext_cycle.active && !ext_cycle.ale && !ext_cycle.write) begin
                ext_rdata <= port0_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read path
    always_comb begin
        case (reg_addr)
            ddps_pkg::ADDR_PORT0_LATCH: next_rdata = port0_in;
            ddps_pkg::ADDR_STACK_TOP:   next_rdata = stack_top_pointer;
            ddps_pkg::ADDR_PTR_A_LOW:   next_rdata = pointer_a_low;
            ddps_pkg::ADDR_PTR_A_HIGH:  next_rdata = pointer_a_high;
            ddps_pkg::ADDR_PTR_B_LOW:   next_rdata = pointer_b_low;
            ddps_pkg::ADDR_PTR_B_HIGH:  next_rdata = pointer_b_high;
            ddps_pkg::ADDR_PTR_SELECT:  next_rdata = {7'h00, pointer_select};
            ddps_pkg::ADDR_P0_DIR_LOW:  next_rdata = port0_direction_low;
            ddps_pkg::ADDR_P0_DIR_HIGH: next_rdata = port0_direction_high;
            ddps_pkg::ADDR_HW_CONFIG1:  next_rdata = hardware_config_one;
            default:                    next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

`default_nettype wire

// [rtl/ddps_pkg.sv]
// package: register map, reset values and carriers for the pointer/stack/port0 bank
package ddps_pkg;

    localparam logic [7:0] ADDR_PORT0_LATCH = 8'h80;
    localparam logic [7:0] ADDR_STACK_TOP   = 8'h81;
    localparam logic [7:0] ADDR_PTR_A_LOW   = 8'h82;
    localparam logic [7:0] ADDR_PTR_A_HIGH  = 8'h83;
    localparam logic [7:0] ADDR_PTR_B_LOW   = 8'h84;
    localparam logic [7:0] ADDR_PTR_B_HIGH  = 8'h85;
    localparam logic [7:0] ADDR_PTR_SELECT  = 8'h86;
    localparam logic [7:0] ADDR_P0_DIR_LOW  = 8'hAC;
    localparam logic [7:0] ADDR_P0_DIR_HIGH = 8'hAD;
    localparam logic [7:0] ADDR_HW_CONFIG1  = 8'h3E;

    localparam logic [7:0] RST_PORT0_LATCH = 8'hFF;
    localparam logic [7:0] RST_STACK_TOP   = 8'h07;
    localparam logic [7:0] RST_PTR_BYTE    = 8'h00;
    localparam logic [7:0] RST_PTR_SELECT  = 8'h00;
    localparam logic [7:0] RST_P0_DIR      = 8'h00;
    localparam logic [7:0] RST_HW_CONFIG1  = 8'h00;

    localparam int SEL_BIT     = 0;
    localparam int EXT_BUS_BIT = 1;

    // core-side stack and pointer operations
    typedef struct packed {
        logic push;
        logic pop;
        logic active_data_pointer_inc;
        logic active_data_pointer_load;
        logic [15:0] active_data_pointer_value;
    } ddps_core_op_t;

    // external memory cycle request from the core
    typedef struct packed {
        logic       active;
        logic       ale;
        logic [7:0] addr_low;
        logic [7:0] wdata;
        logic       write;
    } ddps_ext_cycle_t;

endpackage

// [tb/ddps_pin_model.sv]
// far side of port0: pins seen by the outside world
`timescale 1ns/1ps
`default_nettype none
module ddps_pin_model (
    input  wire logic [7:0] port0_out,
    input  wire logic [7:0] port0_oe,
    input  wire logic [7:0] far_drive,
    output logic      [7:0] port0_in
);
    // pin follows the design where it drives, the far side elsewhere
    assign port0_in = (port0_out & port0_oe) | (far_drive & ~port0_oe);
endmodule
`default_nettype wire

// [tb/ddps_properties.sv]
// checker: port-level properties of the pointer/stack/port0 bank
`timescale 1ns/1ps
`default_nettype none
module ddps_properties (
    input wire logic                      clk,
    input wire logic                      rst,
    input wire logic [7:0]                reg_addr,
    input wire logic [7:0]                reg_wdata,
    input wire logic                      reg_wr,
    input wire logic                      reg_rd,
    input wire logic [7:0]                reg_rdata,
    input wire ddps_pkg::ddps_core_op_t   core_op,
    input wire ddps_pkg::ddps_ext_cycle_t ext_cycle,
    input wire logic [7:0]                stack_addr,
    input wire logic [15:0]               active_data_pointer,
    input wire logic [15:0]               pointer_a,
    input wire logic [7:0]                port0_out,
    input wire logic [7:0]                port0_oe
);
    logic       bus_mode;
    logic       sel_q;
    logic [7:0] dir_l;
    logic [7:0] dir_h;
    wire logic  sp_wr = reg_wr && reg_addr == 8'h81;
    wire logic  quiet = !reg_wr && !core_op.active_data_pointer_load && !core_op.active_data_pointer_inc;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////
    // shadow of config, select and direction registers
    always_ff @(posedge clk) begin
        if (rst) begin
            bus_mode <= 1'b0;
            sel_q    <= 1'b0;
            dir_l    <= 8'h00;
            dir_h    <= 8'h00;
        end else if (reg_wr) begin
            case (reg_addr)
                8'h3E: bus_mode <= reg_wdata[1];
                8'h86: sel_q    <= reg_wdata[0];
                8'hAC: dir_l    <= reg_wdata;
                8'hAD: dir_h    <= reg_wdata;
                default: ;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    a_sp_reset: assert property ($fell(rst) |-> stack_addr == 8'h07)
        else $error("stack pointer not 07 after reset");
    a_push_incr: assert property (core_op.push ##1 (core_op.push && !sp_wr)
        |=> stack_addr == $past(stack_addr) + 8'h01) else $error("push did not increment");
    a_pop_decr: assert property ((core_op.pop && !core_op.push) ##1
        (core_op.pop && !core_op.push && !sp_wr) |=> stack_addr == $past(stack_addr) - 8'h01)
        else $error("pop did not decrement");
    a_load_active: assert property (core_op.active_data_pointer_load && !reg_wr ##1 quiet
        |-> ##2 active_data_pointer == $past(core_op.active_data_pointer_value, 3)) else $error("load lost");
    a_load_ptra: assert property (core_op.active_data_pointer_load && !sel_q && !reg_wr ##1 quiet
        |-> ##2 pointer_a == $past(core_op.active_data_pointer_value, 3)) else $error("pointer a wrong");
    a_select_read: assert property (reg_rd && reg_addr == 8'h86
        |=> reg_rdata == {7'h00, sel_q}) else $error("select read wrong");
    a_bus_address: assert property (bus_mode && ext_cycle.active && ext_cycle.ale
        |=> port0_out == $past(ext_cycle.addr_low) && port0_oe == 8'hFF)
        else $error("address phase wrong");
    a_gpio_drive: assert property (!bus_mode |=> port0_oe == $past(dir_l | dir_h))
        else $error("gpio drive wrong");
    c_push_run: cover property (core_op.push ##1 core_op.push);
    c_bus_cycle: cover property (bus_mode && ext_cycle.active && ext_cycle.ale);
    c_load_b: cover property (core_op.active_data_pointer_load && sel_q);
endmodule
bind ddps_regs ddps_properties u_ddps_properties (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_op(core_op), .ext_cycle(ext_cycle),
    .stack_addr(stack_addr), .active_data_pointer(active_data_pointer),
    .pointer_a(pointer_a), .port0_out(port0_out), .port0_oe(port0_oe));
`default_nettype wire

// [tb/ddps_regs_test.sv]
// testbench: registers, stack, pointers and port0 of ddps_regs
`timescale 1ns/1ps
`default_nettype none
module ddps_regs_test;
    logic clk, rst, reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, stack_addr, port0_in, port0_out;
    logic [7:0] port0_oe, ext_rdata, far_drive, d, e;
    logic [15:0] active_data_pointer, pointer_a, v, w;
    ddps_pkg::ddps_core_op_t c, core_op;
    ddps_pkg::ddps_ext_cycle_t ext_cycle;
    integer seed, failures, compares;
    ddps_regs u_ddps_regs (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_op(core_op),
        .ext_cycle(ext_cycle), .stack_addr(stack_addr), .active_data_pointer(active_data_pointer),
        .pointer_a(pointer_a), .port0_in(port0_in), .port0_out(port0_out),
        .port0_oe(port0_oe), .ext_rdata(ext_rdata));
    ddps_pin_model u_ddps_pin_model (.port0_out(port0_out), .port0_oe(port0_oe),
        .far_drive(far_drive), .port0_in(port0_in));
    task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        @(posedge clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= x;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check("reg_rdata", 16'(reg_rdata), 16'(exp));
    endtask
    task automatic op(input ddps_pkg::ddps_core_op_t o, input int n);
        @(posedge clk);
        core_op <= o;
        repeat (n) @(posedge clk);
        core_op <= '0;
        #1;
    endtask
    task automatic results;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        failures++;
        results();
    end
    initial begin
        seed = 32'h8A8B2E65; failures = 0; compares = 0; rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0;
        reg_addr = 8'h00; reg_wdata = 8'h00; core_op = '0; ext_cycle = '0; far_drive = 8'h3C;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1;
        check("stack_addr", 16'(stack_addr), 16'h0007);
        for (int i = 1; i < 7; i++) rd(8'(8'h80 + i), i == 1 ? 8'h07 : 8'h00);
        for (int i = 1; i < 7; i++) begin
            d = 8'($random(seed));
            if (i == 2) v[7:0] = d;
            if (i == 3) v[15:8] = d;
            wr(8'(8'h80 + i), d);
            rd(8'(8'h80 + i), i == 6 ? {7'h00, d[0]} : d);
        end
        wr(8'h86, 8'hFE);
        repeat (2) @(posedge clk);
        #1;
        check("active_data_pointer", active_data_pointer, v);
        check("pointer_a", pointer_a, v);
        wr(8'h81, 8'hFE);
        c = '0; c.push = 1'b1;
        op(c, 3);
        check("stack_addr", 16'(stack_addr), 16'h0001);
        c = '0; c.pop = 1'b1;
        op(c, 2);
        check("stack_addr", 16'(stack_addr), 16'h00FF);
        rd(8'h81, 8'hFF);
        for (int s = 0; s < 2; s++) begin
            v = s ? 16'hFFFF : 16'($random(seed));
            wr(8'h86, 8'(s));
            c = '0; c.active_data_pointer_load = 1'b1; c.active_data_pointer_value = v;
            op(c, 1);
            @(posedge clk);
            #1;
            check("active_data_pointer", active_data_pointer, v);
            c = '0; c.active_data_pointer_inc = 1'b1;
            op(c, 1);
            @(posedge clk);
            #1;
            check("active_data_pointer", active_data_pointer, v + 16'h0001);
            rd(s ? 8'h85 : 8'h83, 8'((v + 16'h0001) >> 8));
            if (s == 0) w = v + 16'h0001;
        end
        check("pointer_a", pointer_a, w);
        wr(8'h3E, 8'h02);
        d = 8'($random(seed)); e = 8'($random(seed));
        @(posedge clk);
        ext_cycle <= '{1'b1, 1'b1, d, 8'h00, 1'b0}; far_drive <= e;
        @(posedge clk);
        ext_cycle.ale <= 1'b0;
        #1;
        check("port0_out", 16'(port0_out), 16'(d));
        check("port0_oe", 16'(port0_oe), 16'h00FF);
        repeat (2) @(posedge clk);
        ext_cycle.active <= 1'b0;
        #1;
        check("port0_oe", 16'(port0_oe), 16'h0000);
        check("ext_rdata", 16'(ext_rdata), 16'(e));
        @(posedge clk);
        ext_cycle <= '{1'b1, 1'b1, d, e, 1'b1};
        @(posedge clk);
        ext_cycle.ale <= 1'b0;
        @(posedge clk);
        ext_cycle.active <= 1'b0;
        #1;
        check("port0_out", 16'(port0_out), 16'(e));
        wr(8'h3E, 8'h00);
        wr(8'hAC, d); wr(8'hAD, 8'h0F); wr(8'h80, v[7:0]);
        @(posedge clk);
        ext_cycle <= '{1'b1, 1'b1, 8'h5A, 8'h00, 1'b0};
        @(posedge clk);
        #1;
        check("port0_oe", 16'(port0_oe), 16'(d | 8'h0F));
        rd(8'h80, (v[7:0] & (d | 8'h0F)) | (e & ~(d | 8'h0F)));
        results();
    end
endmodule
`default_nettype wire
